// ---- hdl/twe_pkg.sv ----
// shared constants and types of the two-wire memory slave
package twe_pkg;

    // ****************************************
    // word and array geometry
    // ****************************************
    localparam int          BYTE_BITS   = 8;
    localparam int          ADDR_BITS   = 8;
    localparam int          COL_BITS    = 4;
    localparam int          PAGE_BYTES  = 16;
    localparam int          MEM_BYTES   = 256;
    localparam logic [3:0]  BIT_ACK     = 4'h8;
    localparam logic [3:0]  DEV_TYPE    = 4'ha;

    // ****************************************
    // pin positions in the synchroniser bundle
    // ****************************************
    localparam int          PIN_SCL     = 0;
    localparam int          PIN_SDA     = 1;
    localparam int          PIN_CS0     = 2;
    localparam int          PIN_CS1     = 3;
    localparam int          PIN_CS2     = 4;
    localparam int          PIN_WP      = 5;
    localparam int          PIN_COUNT   = 6;

    // ****************************************
    // timing
    // ****************************************
    localparam int          PROGRAM_CYCLE_TIME_MS = 5;
    localparam int          CLK_FREQ_KHZ          = 200000;
    localparam int          PROG_CYCLES           = PROGRAM_CYCLE_TIME_MS * CLK_FREQ_KHZ;

    // ****************************************
    // protocol states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DEV    = 3'b001,
        ST_WADDR  = 3'b010,
        ST_WDATA  = 3'b011,
        ST_RDATA  = 3'b100,
        ST_IGNORE = 3'b101,
        ST_PROG   = 3'b110
    } twe_state_t;

endpackage : twe_pkg

// ---- hdl/twe_pin_sync.sv ----
// two-flop synchroniser bank for the slave's pins
`timescale 1ns/1ps
`default_nettype none

module twe_pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("twe_pin_sync: WIDTH must be at least 1");
        end
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            // first stage feeds only the second stage
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    meta_q[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (clk_en_in) begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule : twe_pin_sync

`default_nettype wire

// ---- hdl/twe_slave.sv ----
// two-wire slave of a 256-byte memory with paged, self-timed writes
`timescale 1ns/1ps
`default_nettype none

module twe_slave #(
    parameter int unsigned PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic clk_en_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic chip_select_bit_2_in,
    input  wire logic chip_select_bit_1_in,
    input  wire logic chip_select_bit_0_in,
    input  wire logic write_protect_in,
    output var  logic sda_out,
    output var  logic sda_oe_n_out,
    output var  logic busy_out,
    output var  logic standby_out
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYCLES - 1);

    generate
        if (PROG_CYCLES < 1) begin : g_bad
            $error("twe_slave: PROG_CYCLES must be at least 1");
        end
    endgenerate

    // ****************************************
    // pin synchronisers and line events
    // ****************************************
    logic [twe_pkg::PIN_COUNT-1:0] pins_raw;
    logic [twe_pkg::PIN_COUNT-1:0] pins_s;
    logic                          scl_prev_q;
    logic                          sda_prev_q;

    assign pins_raw[twe_pkg::PIN_SCL] = scl_in;
    assign pins_raw[twe_pkg::PIN_SDA] = sda_in;
    assign pins_raw[twe_pkg::PIN_CS0] = chip_select_bit_0_in;
    assign pins_raw[twe_pkg::PIN_CS1] = chip_select_bit_1_in;
    assign pins_raw[twe_pkg::PIN_CS2] = chip_select_bit_2_in;
    assign pins_raw[twe_pkg::PIN_WP]  = write_protect_in;

    twe_pin_sync #(
        .WIDTH (twe_pkg::PIN_COUNT)
    ) u_sync (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .clk_en_in (clk_en_in),
        .async_in  (pins_raw),
        .sync_out  (pins_s)
    );

    wire       scl_s = pins_s[twe_pkg::PIN_SCL];
    wire       sda_s = pins_s[twe_pkg::PIN_SDA];
    wire       wp_s  = pins_s[twe_pkg::PIN_WP];
    wire [2:0] cs_s  = {pins_s[twe_pkg::PIN_CS2], pins_s[twe_pkg::PIN_CS1], pins_s[twe_pkg::PIN_CS0]};

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            scl_prev_q <= 1'b0;
            sda_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    // data edges while the clock stays high mark frame boundaries
    wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ****************************************
    // protocol state
    // ****************************************
    twe_pkg::twe_state_t              state_q;
    logic [3:0]                       bitcnt_q;
    logic [7:0]                       shift_q;
    logic                             ack_q;
    logic                             master_ack_q;
    logic [twe_pkg::ADDR_BITS-1:0]    addr_q;
    logic [twe_pkg::PAGE_BYTES-1:0]   valid_q;
    logic [7:0]                       page_q [twe_pkg::PAGE_BYTES];
    logic [7:0]                       mem_q  [twe_pkg::MEM_BYTES];
    logic [CNT_W-1:0]                 prog_cnt_q;
    logic                             sda_oe_n_q;

    // all pin activity is ignored while the array programs
    wire busy = (state_q == twe_pkg::ST_PROG);
    wire live = ~busy;
    wire in_frame = (state_q != twe_pkg::ST_IDLE) && (state_q != twe_pkg::ST_IGNORE) && live;

    // unconnected select pins are pulled low at the pad
    wire dev_match = (shift_q[7:4] == twe_pkg::DEV_TYPE) && (shift_q[3:1] == cs_s);
    wire dev_read  = shift_q[0];

    wire bit_in    = in_frame & scl_rise & ~ack_q & (bitcnt_q < twe_pkg::BIT_ACK);
    wire byte_done = in_frame & scl_fall & ~ack_q & (bitcnt_q == twe_pkg::BIT_ACK);
    wire ack_rise  = in_frame & scl_rise & ack_q;
    wire ack_end   = in_frame & scl_fall & ack_q;
    wire rd_fall   = in_frame & scl_fall & ~ack_q & (bitcnt_q < twe_pkg::BIT_ACK)
                     & (state_q == twe_pkg::ST_RDATA);
    wire frame_ev  = live & (start_ev | stop_ev);

    wire ack_ok = ((state_q == twe_pkg::ST_DEV) && dev_match)
                  || (state_q == twe_pkg::ST_WADDR)
                  || (state_q == twe_pkg::ST_WDATA);

    // read data path never looks at the protect pin
    wire read_load = ack_end & (state_q == twe_pkg::ST_RDATA) & master_ack_q;
    wire [7:0] rd_byte = mem_q[addr_q];

    wire wr_byte  = byte_done & (state_q == twe_pkg::ST_WDATA);
    wire prog_go  = live & stop_ev & (state_q == twe_pkg::ST_WDATA)
                    & (|valid_q) & ~wp_s;
    wire prog_done = busy & (prog_cnt_q == '0);

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= twe_pkg::ST_IDLE;
        end else if (clk_en_in) begin
            if (busy) begin
                if (prog_done) begin
                    state_q <= twe_pkg::ST_IDLE;
                end
            end else if (start_ev) begin
                // a start outside programming restarts decoding, which also ends a bus recovery
                state_q <= twe_pkg::ST_DEV;
            end else if (stop_ev) begin
                state_q <= prog_go ? twe_pkg::ST_PROG : twe_pkg::ST_IDLE;
            end else if (byte_done) begin
                unique case (state_q)
                    twe_pkg::ST_DEV: begin
                        if (!dev_match) begin
                            state_q <= twe_pkg::ST_IDLE;
                        end else begin
                            state_q <= dev_read ? twe_pkg::ST_RDATA : twe_pkg::ST_WADDR;
                        end
                    end
                    twe_pkg::ST_WADDR: begin
                        state_q <= twe_pkg::ST_WDATA;
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end else if (ack_rise && (state_q == twe_pkg::ST_RDATA) && sda_s) begin
                // no master acknowledge: park until the next start or stop
                state_q <= twe_pkg::ST_IGNORE;
            end
        end
    end

    // ****************************************
    // bit counter and shifter
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            bitcnt_q <= 4'h0;
            ack_q    <= 1'b0;
            shift_q  <= 8'h00;
        end else if (clk_en_in) begin
            if (frame_ev) begin
                bitcnt_q <= 4'h0;
                ack_q    <= 1'b0;
            end else if (bit_in) begin
                shift_q  <= {shift_q[6:0], sda_s};
                bitcnt_q <= bitcnt_q + 4'h1;
            end else if (byte_done) begin
                ack_q    <= 1'b1;
            end else if (ack_end) begin
                ack_q    <= 1'b0;
                bitcnt_q <= 4'h0;
                if (read_load) begin
                    shift_q <= rd_byte;
                end
            end
        end
    end

    // device's own ack in the read address slot samples as a master ack
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            master_ack_q <= 1'b0;
        end else if (clk_en_in && ack_rise) begin
            master_ack_q <= ~sda_s;
        end
    end

    // ****************************************
    // open-drain data driver
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sda_oe_n_q <= 1'b1;
        end else if (clk_en_in) begin
            if (busy || frame_ev) begin
                sda_oe_n_q <= 1'b1;
            end else if (byte_done) begin
                sda_oe_n_q <= ~ack_ok;
            end else if (ack_end) begin
                sda_oe_n_q <= read_load ? rd_byte[7] : 1'b1;
            end else if (rd_fall) begin
                sda_oe_n_q <= shift_q[7];
            end
        end
    end

    // ****************************************
    // address pointer and page buffer
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            addr_q <= '0;
        end else if (clk_en_in) begin
            if (byte_done && (state_q == twe_pkg::ST_WADDR)) begin
                addr_q <= shift_q;
            end else if (wr_byte) begin
                // row bits hold, column wraps inside the page
                addr_q[3:0] <= addr_q[3:0] + 4'h1;
            end else if (read_load) begin
                addr_q <= addr_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            valid_q <= '0;
        end else if (clk_en_in) begin
            // a fresh start drops an unfinished page, e.g. a dummy write
            if ((live && start_ev) || prog_done) begin
                valid_q <= '0;
            end else if (wr_byte) begin
                valid_q[addr_q[3:0]] <= 1'b1;
            end
        end
    end

    // later bytes to a reused column simply overwrite the slot
    always_ff @(posedge clock_in) begin
        if (clk_en_in && wr_byte) begin
            page_q[addr_q[3:0]] <= shift_q;
        end
    end

    // ****************************************
    // timed programming and array
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prog_cnt_q <= '0;
        end else if (clk_en_in) begin
            if (prog_go) begin
                prog_cnt_q <= PROG_LOAD;
            end else if (busy && !prog_done) begin
                prog_cnt_q <= prog_cnt_q - CNT_W'(1);
            end
        end
    end

    // only loaded columns are written, so partial pages keep the rest
    always_ff @(posedge clock_in) begin
        if (clk_en_in && prog_done) begin
            for (int j = 0; j < twe_pkg::PAGE_BYTES; j++) begin
                if (valid_q[j]) begin
                    mem_q[{addr_q[7:4], 4'(j)}] <= page_q[j];
                end
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic busy_q;
    logic standby_q;
    logic sda_lvl_q;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            busy_q    <= 1'b0;
            standby_q <= 1'b1;
            sda_lvl_q <= 1'b0;
        end else if (clk_en_in) begin
            busy_q    <= busy;
            standby_q <= (state_q == twe_pkg::ST_IDLE);
            sda_lvl_q <= 1'b0;
        end
    end

    assign sda_out      = sda_lvl_q;
    assign sda_oe_n_out = sda_oe_n_q;
    assign busy_out     = busy_q;
    assign standby_out  = standby_q;

endmodule : twe_slave

`default_nettype wire

// ---- tb/twe_slave_chk.sv ----
// concurrent checks on the two-wire memory slave's pins
`timescale 1ns/1ps
`default_nettype none

module twe_slave_chk #(
    parameter int unsigned PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic clk_en_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic chip_select_bit_2_in,
    input  wire logic chip_select_bit_1_in,
    input  wire logic chip_select_bit_0_in,
    input  wire logic write_protect_in,
    input  wire logic sda_out,
    input  wire logic sda_oe_n_out,
    input  wire logic busy_out,
    input  wire logic standby_out
);
    // ****************************************
    // programming length counter
    // ****************************************
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;

    assign busy_cnt_d = busy_out ? busy_cnt_q + 32'h1 : 32'h0;

    always_ff @(posedge clock_in) begin
        busy_cnt_q <= rst_in ? 32'h0 : busy_cnt_d;
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    drive_low_only_a: assert property (sda_out == 1'b0)
        else $error("data pin value is not low");
    reset_standby_a: assert property ($fell(rst_in) |-> standby_out && !busy_out && sda_oe_n_out)
        else $error("not idle after reset");
    pin_clk_low_a: assert property ($changed(sda_oe_n_out) |-> !scl_in)
        else $error("data pin moved while serial clock high");
    ack_holds_a: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*8])
        else $error("acknowledge dropped early");
    busy_silent_a: assert property (busy_out |-> sda_oe_n_out)
        else $error("pin driven during programming");
    busy_not_idle_a: assert property (busy_out |-> !standby_out)
        else $error("standby while programming");
    busy_max_a: assert property (busy_out |-> busy_cnt_q <= PROG_CYCLES + 2)
        else $error("programming longer than its count");
    busy_min_a: assert property ($fell(busy_out) |-> busy_cnt_q + 3 >= PROG_CYCLES)
        else $error("programming shorter than its count");
    prog_to_idle_a: assert property ($fell(busy_out) |-> standby_out)
        else $error("no standby after programming");
    idle_silent_a: assert property (standby_out |-> sda_oe_n_out)
        else $error("pin driven in standby");

    cover property ($rose(busy_out));
    cover property ($fell(sda_oe_n_out));
    cover property ($fell(busy_out) ##1 standby_out);

endmodule : twe_slave_chk

bind twe_slave twe_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) twe_slave_chk_inst (
    .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .scl_in(scl_in), .sda_in(sda_in),
    .chip_select_bit_2_in(chip_select_bit_2_in), .chip_select_bit_1_in(chip_select_bit_1_in),
    .chip_select_bit_0_in(chip_select_bit_0_in), .write_protect_in(write_protect_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .busy_out(busy_out), .standby_out(standby_out));

`default_nettype wire

// ---- tb/twe_master_model.sv ----
// bus master model driving serial clock and open-drain data
`timescale 1ns/1ps
`default_nettype none

module twe_master_model (
    input  wire logic clock_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_rel_out
);
    initial begin
        scl_out     = 1'b1;
        sda_rel_out = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wait_clk

    // one bit of 32 cycles; data moves only mid-low
    task automatic put_bit(input logic b, output logic got);
        sda_rel_out <= b;
        wait_clk(8);
        scl_out <= 1'b1;
        wait_clk(8);
        got = sda_in;
        wait_clk(8);
        scl_out <= 1'b0;
        wait_clk(8);
    endtask : put_bit

    task automatic start_c();
        sda_rel_out <= 1'b1;
        wait_clk(8);
        scl_out <= 1'b1;
        wait_clk(16);
        sda_rel_out <= 1'b0;
        wait_clk(16);
        scl_out <= 1'b0;
        wait_clk(8);
    endtask : start_c

    task automatic stop_c();
        sda_rel_out <= 1'b0;
        wait_clk(8);
        scl_out <= 1'b1;
        wait_clk(16);
        sda_rel_out <= 1'b1;
        wait_clk(16);
    endtask : stop_c

    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], g);
        end
        put_bit(1'b1, g);
        ack = ~g;
    endtask : byte_w

    task automatic byte_r(input logic more, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, g);
            d[i] = g;
        end
        put_bit(~more, g);
    endtask : byte_r

    task automatic recover();
        logic g;
        start_c();
        repeat (18) put_bit(1'b1, g);
        start_c();
    endtask : recover

endmodule : twe_master_model

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       clock_in = 1'b0;
    logic       rst_in   = 1'b1;
    logic [2:0] cs_q     = 3'h0;
    logic       wp_q     = 1'b0;
    logic       scl;
    logic       sda_rel;
    logic       sda_wire;
    logic       sda_o;
    logic       sda_oe_n;
    logic       busy;
    logic       standby;
    logic [7:0] exp_mem [256];
    int         seed         = 55685;
    int         errors       = 0;
    int         total_checks = 0;

    always #2.5 clock_in = ~clock_in;

    // pull-up unless someone pulls low
    assign sda_wire = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;

    twe_slave #(.PROG_CYCLES(400)) twe_slave_inst (
        .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(1'b1), .scl_in(scl), .sda_in(sda_wire),
        .chip_select_bit_2_in(cs_q[2]), .chip_select_bit_1_in(cs_q[1]), .chip_select_bit_0_in(cs_q[0]),
        .write_protect_in(wp_q), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .busy_out(busy),
        .standby_out(standby));

    twe_master_model twe_master_model_inst (
        .clock_in(clock_in), .sda_in(sda_wire), .scl_out(scl), .sda_rel_out(sda_rel));

    // ****************************************
    // expectations and helpers
    // ****************************************
    function automatic logic [7:0] dev_word(input logic [2:0] cs, input logic rd);
        return {twe_pkg::DEV_TYPE, cs, rd};
    endfunction : dev_word

    function automatic logic [7:0] col_addr(input logic [7:0] base, input int i);
        return {base[7:4], base[3:0] + 4'(i)};
    endfunction : col_addr

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic sta();
        twe_master_model_inst.start_c();
    endtask : sta

    task automatic sto();
        twe_master_model_inst.stop_c();
    endtask : sto

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        twe_master_model_inst.byte_w(d, a);
        chk("ack", {7'h00, exp_ack}, {7'h00, a});
    endtask : send

    task automatic write_seq(input logic [7:0] addr, input int n);
        logic [7:0] d;
        sta();
        send(dev_word(cs_q, 1'b0), 1'b1);
        send(addr, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            send(d, 1'b1);
            if (!wp_q) begin
                exp_mem[col_addr(addr, i)] = d;
            end
        end
        sto();
    endtask : write_seq

    task automatic read_seq(input logic [7:0] addr, input int n);
        logic [7:0] d;
        sta();
        send(dev_word(cs_q, 1'b0), 1'b1);
        send(addr, 1'b1);
        sta();
        send(dev_word(cs_q, 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            twe_master_model_inst.byte_r(i < n - 1, d);
            chk("read data", exp_mem[addr + 8'(i)], d);
        end
        sto();
        repeat (8) @(posedge clock_in);
        chk("standby after read", 8'h01, {7'h00, standby});
    endtask : read_seq

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge clock_in);
            k++;
        end
        if (k == 1000) begin
            errors++;
            $display("[ERR] busy expected 0 seen %b", busy);
            report_and_stop();
        end else begin
            repeat (2) @(posedge clock_in);
            chk("standby", 8'h01, {7'h00, standby});
        end
    endtask : wait_idle

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] a1;
        logic [7:0] row;
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        cs_q   <= 3'($random(seed));
        @(posedge clock_in);
        #1;
        chk("reset standby", 8'h01, {7'h00, standby});
        chk("reset busy", 8'h00, {7'h00, busy});
        chk("reset release", 8'h01, {7'h00, sda_oe_n});
        repeat (8) @(posedge clock_in);
        a1 = 8'($random(seed));
        write_seq(a1, 1);
        chk("busy after stop", 8'h01, {7'h00, busy});
        sta();
        send(dev_word(cs_q, 1'b0), 1'b0);
        sto();
        wait_idle();
        row = 8'($random(seed));
        write_seq({row[7:4], 4'he}, 18);
        wait_idle();
        read_seq({row[7:4], 4'h0}, 16);
        read_seq(a1, 1);
        // flip each select bit, then the type code
        for (int k = 0; k < 4; k++) begin
            sta();
            send(dev_word(cs_q, 1'b0) ^ (8'h02 << k), 1'b0);
            // a stop would idle every state but programming and a loaded, unprotected write, so look before it
            chk("standby after mismatch", 8'h01, {7'h00, standby});
            sto();
        end
        wp_q <= 1'b1;
        @(posedge clock_in);
        write_seq(a1, 1);
        repeat (8) @(posedge clock_in);
        chk("busy with protect", 8'h00, {7'h00, busy});
        read_seq(a1, 1);
        wp_q <= 1'b0;
        @(posedge clock_in);
        sta();
        send(dev_word(cs_q, 1'b0), 1'b1);
        twe_master_model_inst.recover();
        sto();
        write_seq(a1 & 8'hf0, 2);
        wait_idle();
        read_seq(a1 & 8'hf0, 2);
        report_and_stop();
    end

endmodule : testbench

`default_nettype wire
